/* hdl/pump_level_regs.v */
// command decoder and storage for partial pump divider and common level codes
// assumes all bus pins synchronous to sys_clk; host keeps the read strobe high
// assumes pump_source_clock is a one-clock tick, partial_mode a level
// a byte counts once, at the first clock edge that sees write_strobe_n high again
`timescale 1ns/1ps
`include "pump_level_map.vh"
// Contract
// - command at select low, parameter high, rising write
// - 0xc4 selects pump divider, one parameter
// - bits 6:4 stages two-four, 2:0 stage one
// - stage one divides source by two^code
// - stages two-four divide by two^(code+1)
// - reset loads divider codes 010 and 011
// - 0xc5 selects common levels, two parameters
// - low seven bits: high then low code
// - high code: 2.700 V plus 25 mV steps
// - low code: -2.500 V plus 25 mV steps
// - reset loads level codes 0110001, 0111100
// - commands taken only with extended enable high
// - level command accepted in every power state
module pump_level_regs
(
	// clock and reset
	input  wire        sys_clk,
	input  wire        sys_rst,
	input  wire        soft_reset,
	// parallel command bus
	input  wire [15:0] bus_data,
	input  wire        data_command_select,
	input  wire        read_strobe_n,
	input  wire        write_strobe_n,
	input  wire        extended_cmd_enable,
	// display state
	input  wire        partial_mode,
	input  wire        pump_source_clock,
	// stored codes
	output reg  [2:0]  pump1_partial_div,
	output reg  [2:0]  pump234_partial_div,
	output reg  [6:0]  common_high_code,
	output reg  [6:0]  common_low_code,
	// level outputs in millivolts
	output reg  [12:0] common_high_level,
	output reg  [12:0] common_low_level_mag,
	// pump stage enables and status
	output wire        pump1_tick,
	output wire        pump234_tick,
	output reg         code_error
);
	// ==========================================
	// sequencer states
	localparam [1:0] ST_IDLE     = 2'h0;
	localparam [1:0] ST_PUMP_P1  = 2'h1;
	localparam [1:0] ST_LEVEL_P1 = 2'h2;
	localparam [1:0] ST_LEVEL_P2 = 2'h3;

	// ==========================================
	// helpers
	// 25 mV per step from a base, result in mV
	function [12:0] level_mv;
		input [12:0] base;
		input [6:0]  code;
		begin
			level_mv = base + ({6'h00, code} * `LEVEL_STEP_MV);
		end
	endfunction

	// all-ones divider code has no defined pump rate
	function div_prohibited;
		input [2:0] code;
		begin
			div_prohibited = (code == `DIV_PROHIBITED);
		end
	endfunction

	// codes past 0 V are reserved
	function low_reserved;
		input [6:0] code;
		begin
			low_reserved = (code > `LOW_CODE_MAX);
		end
	endfunction

	// reserved codes pinned at 0 V so the level never wraps
	function [6:0] low_clip;
		input [6:0] code;
		begin
			low_clip = low_reserved(code) ? `LOW_CODE_MAX : code;
		end
	endfunction

	// ==========================================
	// write strobe edge
	// one-clock pulse once the strobe is seen high again
	wire write_rise;
	strobe_edge u_edge
	(
		.sys_clk        (sys_clk),
		.sys_rst        (sys_rst),
		.write_strobe_n (write_strobe_n),
		.write_rise     (write_rise)
	);

	// only bits 7:0 carry meaning; upper lanes ignored
	wire [7:0] byte_in;
	wire       wr_ok;
	wire       is_cmd;
	wire       is_par;

	assign byte_in = bus_data[7:0];
	assign wr_ok   = write_rise & read_strobe_n;
	assign is_cmd  = wr_ok & ~data_command_select;
	assign is_par  = wr_ok & data_command_select;

	// command bytes count only with the extended set open
	wire       cmd_pump;
	wire       cmd_level;
	assign cmd_pump  = extended_cmd_enable & (byte_in == `CMD_PARTIAL_PUMP_DIVIDER);
	assign cmd_level = extended_cmd_enable & (byte_in == `CMD_COMMON_LEVEL_CODES);

	// ==========================================
	// parameter sequencer
	reg  [1:0] state_r;
	reg  [1:0] state_nxt;
	wire       rst_any;
	assign rst_any = sys_rst | soft_reset;

	always @*
	begin
		state_nxt = state_r;
		if (is_cmd)
		begin
			// any command byte aborts a pending sequence
			state_nxt = ST_IDLE;
			// no power-state gating: accepted asleep too
			if (cmd_pump)
				state_nxt = ST_PUMP_P1;
			else if (cmd_level)
				state_nxt = ST_LEVEL_P1;
		end
		else if (is_par)
		begin
			case (state_r)
				ST_PUMP_P1:
				begin
					// a single byte completes the divider command
					state_nxt = ST_IDLE;
				end
				ST_LEVEL_P1:
				begin
					state_nxt = ST_LEVEL_P2;
				end
				ST_LEVEL_P2:
				begin
					state_nxt = ST_IDLE;
				end
				default:
				begin
					// stray parameter with no open command
					state_nxt = ST_IDLE;
				end
			endcase
		end
	end

	// soft reset also drops a half-written sequence
	always @(posedge sys_clk)
	begin
		if (rst_any)
			state_r <= ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// ==========================================
	// stored codes, next values
	reg [2:0] pump1_nxt;
	reg [2:0] pump234_nxt;
	reg [6:0] high_nxt;
	reg [6:0] low_nxt;

	always @*
	begin
		pump1_nxt   = pump1_partial_div;
		pump234_nxt = pump234_partial_div;
		high_nxt    = common_high_code;
		low_nxt     = common_low_code;
		// parameters with no open command change nothing
		if (is_par)
		begin
			case (state_r)
				ST_PUMP_P1:
				begin
					pump1_nxt   = byte_in[`PUMP1_LSB+`PUMP1_W-1:`PUMP1_LSB];
					pump234_nxt = byte_in[`PUMP234_LSB+`PUMP1_W-1:`PUMP234_LSB];
				end
				ST_LEVEL_P1:
				begin
					high_nxt = byte_in[`CODE7_W-1:`CODE_LSB];
				end
				ST_LEVEL_P2:
				begin
					low_nxt = byte_in[`CODE7_W-1:`CODE_LSB];
				end
				default:
				begin
					low_nxt = common_low_code;
				end
			endcase
		end
	end

	// ==========================================
	// stored codes
	// hardware reset and soft reset alike restore the defaults
	always @(posedge sys_clk)
	begin
		if (rst_any)
		begin
			pump1_partial_div   <= `PUMP1_RESET;
			pump234_partial_div <= `PUMP234_RESET;
			common_high_code    <= `HIGH_CODE_RESET;
			common_low_code     <= `LOW_CODE_RESET;
		end
		else
		begin
			pump1_partial_div   <= pump1_nxt;
			pump234_partial_div <= pump234_nxt;
			common_high_code    <= high_nxt;
			common_low_code     <= low_nxt;
		end
	end

	// ==========================================
	// level codes to millivolts
	// low level is negative: output is magnitude below ground
	wire [12:0] high_level_nxt;
	wire [12:0] low_level_nxt;
	assign high_level_nxt = level_mv(`HIGH_BASE_MV, common_high_code);
	assign low_level_nxt  = `LOW_BASE_MV - level_mv(`LEVEL_ZERO_MV, low_clip(common_low_code));

	// levels trail the codes by one clock; soft reset leaves them following
	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			common_high_level    <= `LEVEL_RESET;
			common_low_level_mag <= `LEVEL_RESET;
		end
		else
		begin
			common_high_level    <= high_level_nxt;
			common_low_level_mag <= low_level_nxt;
		end
	end

	// ==========================================
	// host misuse flag
	// hardware still stores what was written; the flag only reports it
	wire bad_pump1;
	wire bad_pump234;
	wire bad_low;
	assign bad_pump1   = div_prohibited(pump1_partial_div);
	assign bad_pump234 = div_prohibited(pump234_partial_div);
	assign bad_low     = low_reserved(common_low_code);

	always @(posedge sys_clk)
	begin
		if (rst_any)
		begin
			code_error <= 1'b0;
		end
		else
		begin
			code_error <= bad_pump1 | bad_pump234 | bad_low;
		end
	end

	// ==========================================
	// partial mode pump dividers
	// stages two-four run one octave below stage one at equal codes 0 to 6
	wire [3:0] shift1;
	wire [3:0] shift234;
	assign shift1   = {1'b0, pump1_partial_div};
	assign shift234 = {1'b0, pump234_partial_div} + `STAGE234_SHIFT_ADD;

	pump_divider u_pump1
	(
		.sys_clk           (sys_clk),
		.sys_rst           (sys_rst),
		.enable            (partial_mode),
		.pump_source_clock (pump_source_clock),
		.shift             (shift1),
		.pump_tick         (pump1_tick)
	);

	pump_divider u_pump234
	(
		.sys_clk           (sys_clk),
		.sys_rst           (sys_rst),
		.enable            (partial_mode),
		.pump_source_clock (pump_source_clock),
		.shift             (shift234),
		.pump_tick         (pump234_tick)
	);
endmodule // pump_level_regs

/* hdl/pump_level_map.vh */
// constants for the partial pump divider and common level command decoder
// assumes inclusion by pump_level_regs, the only design file of this block that includes it
`ifndef PUMP_LEVEL_MAP_VH
`define PUMP_LEVEL_MAP_VH
// ==========================================
// command codes
`define CMD_PARTIAL_PUMP_DIVIDER 8'hc4
`define CMD_COMMON_LEVEL_CODES   8'hc5
// ==========================================
// field layout
`define PUMP1_LSB                0
`define PUMP1_W                  3
`define PUMP234_LSB              4
`define CODE_LSB                 0
`define CODE7_W                  7
`define DIV_PROHIBITED           3'h7
`define LOW_CODE_MAX             7'h64
`define STAGE234_SHIFT_ADD       4'h1
// ==========================================
// level arithmetic, millivolts
`define HIGH_BASE_MV             13'ha8c
`define LOW_BASE_MV              13'h9c4
`define LEVEL_STEP_MV            13'h019
`define LEVEL_ZERO_MV            13'h000
`define LEVEL_RESET              13'h000
// ==========================================
// reset values
`define PUMP1_RESET              3'h2
`define PUMP234_RESET            3'h3
`define HIGH_CODE_RESET          7'h31
`define LOW_CODE_RESET           7'h3c
`endif

/* hdl/strobe_edge.v */
// rising edge detector for the active-low write strobe
// assumes the strobe is already synchronous to sys_clk
`timescale 1ns/1ps
module strobe_edge
(
	// clock and reset
	input  wire sys_clk,
	input  wire sys_rst,
	// strobe
	input  wire write_strobe_n,
	output wire write_rise
);
	reg prev_r;
	always @(posedge sys_clk)
	begin
		if (sys_rst)
			prev_r <= 1'b1;
		else
			prev_r <= write_strobe_n;
	end
	assign write_rise = write_strobe_n & ~prev_r;
endmodule // strobe_edge

/* hdl/pump_divider.v */
// pump clock enable generator: fires once every 2**shift[2:0] source ticks
// assumes pump_source_clock is a synchronous tick in the sys_clk domain
`timescale 1ns/1ps
module pump_divider
(
	// clock and reset
	input  wire       sys_clk,
	input  wire       sys_rst,
	// control
	input  wire       enable,
	input  wire       pump_source_clock,
	input  wire [3:0] shift,
	// output
	output reg        pump_tick
);
	reg  [7:0] cnt_r;
	wire [7:0] last;
	// mask of 2**shift[2:0] - 1; a shift of 8 gives mask 0
	assign last = (8'h01 << shift[2:0]) - 8'h01;
	always @(posedge sys_clk)
	begin
		if (sys_rst | ~enable)
		begin
			cnt_r     <= 8'h00;
			pump_tick <= 1'b0;
		end
		else if (pump_source_clock)
		begin
			pump_tick <= (cnt_r >= last);
			cnt_r     <= (cnt_r >= last) ? 8'h00 : cnt_r + 8'h01;
		end
		else
			pump_tick <= 1'b0;
	end
endmodule // pump_divider

/* bench/pump_level_monitor.sv */
// checker for the pump divider and common level decoder
// assumes binding onto pump_level_regs
`timescale 1ns/1ps
module pump_level_monitor
(
	// clock and reset
	input wire        sys_clk,
	input wire        sys_rst,
	input wire        soft_reset,
	// bus and state
	input wire [15:0] bus_data,
	input wire        data_command_select,
	input wire        read_strobe_n,
	input wire        write_strobe_n,
	input wire        extended_cmd_enable,
	input wire        partial_mode,
	// outputs
	input wire [2:0]  pump1_partial_div,
	input wire [2:0]  pump234_partial_div,
	input wire [6:0]  common_high_code,
	input wire [6:0]  common_low_code,
	input wire [12:0] common_high_level,
	input wire [12:0] common_low_level_mag,
	input wire        pump1_tick,
	input wire        pump234_tick,
	input wire        code_error
);
	// ==========================================
	// reference sequencer
	reg        wr_q_r;
	reg [1:0]  pend_r;
	wire       rise = write_strobe_n & ~wr_q_r & read_strobe_n;
	wire       prm  = rise & data_command_select & extended_cmd_enable;
	wire [19:0] codes = {pump1_partial_div, pump234_partial_div, common_high_code, common_low_code};
	always @(posedge sys_clk)
	begin
		wr_q_r <= write_strobe_n;
		if (sys_rst | soft_reset)
			pend_r <= 2'h0;
		else if (rise & ~data_command_select)
			pend_r <= ~extended_cmd_enable ? 2'h0 : bus_data[7:0] == 8'hc4 ? 2'h1 : {bus_data[7:0] == 8'hc5, 1'b0};
		else if (prm)
			pend_r <= pend_r == 2'h2 ? 2'h3 : 2'h0;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// ==========================================
	// assertions
	a_high_map: assert property (1 |=> common_high_level == 13'd2700 + 13'd25 * $past(common_high_code))
		else $error("high level wrong");
	a_low_map: assert property (1 |=> common_low_level_mag ==
		13'd2500 - 13'd25 * ($past(common_low_code) > 7'h64 ? 7'h64 : $past(common_low_code))) else $error("low level wrong");
	a_reset_codes: assert property ($fell(sys_rst) |-> codes == 20'h4d8bc) else $error("reset codes wrong");
	a_soft_codes: assert property (soft_reset |=> codes == 20'h4d8bc) else $error("soft reset codes wrong");
	a_change_cause: assert property (!$stable(codes) |-> $past(prm && pend_r != 2'h0) || $past(soft_reset))
		else $error("codes changed without a write");
	a_pump_fields: assert property (prm && pend_r == 2'h1 |=>
		{pump234_partial_div, pump1_partial_div} == $past({bus_data[6:4], bus_data[2:0]})) else $error("pump fields wrong");
	a_high_param: assert property (prm && pend_r == 2'h2 |=> common_high_code == $past(bus_data[6:0]))
		else $error("high code wrong");
	a_low_param: assert property (prm && pend_r == 2'h3 |=> common_low_code == $past(bus_data[6:0]))
		else $error("low code wrong");
	a_idle_ticks: assert property (!partial_mode [*2] |-> !pump1_tick && !pump234_tick)
		else $error("pump tick outside partial mode");
	a_error_flag: assert property (!$past(soft_reset) |-> code_error ==
		($past(pump1_partial_div) == 3'h7 || $past(pump234_partial_div) == 3'h7 || $past(common_low_code) > 7'h64))
		else $error("misuse flag wrong");
	c_level: cover property (prm && pend_r == 2'h3);
	c_tick: cover property (pump234_tick);
	c_soft: cover property (soft_reset);
endmodule // pump_level_monitor
bind pump_level_regs pump_level_monitor mon (.sys_clk(sys_clk), .sys_rst(sys_rst), .soft_reset(soft_reset),
	.bus_data(bus_data), .data_command_select(data_command_select), .read_strobe_n(read_strobe_n),
	.write_strobe_n(write_strobe_n), .extended_cmd_enable(extended_cmd_enable), .partial_mode(partial_mode),
	.pump1_partial_div(pump1_partial_div), .pump234_partial_div(pump234_partial_div),
	.common_high_code(common_high_code), .common_low_code(common_low_code), .common_high_level(common_high_level),
	.common_low_level_mag(common_low_level_mag), .pump1_tick(pump1_tick), .pump234_tick(pump234_tick),
	.code_error(code_error));

/* bench/host_model.sv */
// host side: writes command and parameter bytes
// assumes put is called at a falling edge
`timescale 1ns/1ps
module host_model
(
	// clock
	input wire        sys_clk,
	// parallel bus
	output reg [15:0] bus_data,
	output reg        data_command_select,
	output reg        read_strobe_n,
	output reg        write_strobe_n
);
	initial
	begin
		bus_data = 16'h0000;
		data_command_select = 1'b0;
		read_strobe_n = 1'b1;
		write_strobe_n = 1'b1;
	end
	// callers keep divider and low codes legal
	task put(input dcs, input [7:0] val);
	begin
		@(negedge sys_clk);
		data_command_select = dcs;
		bus_data = {~val, val}; // upper byte is junk
		write_strobe_n = 1'b0;
		@(negedge sys_clk);
		write_strobe_n = 1'b1;
		@(negedge sys_clk);
		bus_data = ~bus_data; // released lines never keep the old byte
	end
	endtask
endmodule // host_model

/* bench/partial_pump_and_common_level_regs_tb.sv */
// bench for the pump divider and common level decoder
// assumes host_model and the monitor bind are compiled
`timescale 1ns/1ps
module partial_pump_and_common_level_regs_tb;
	reg         clk = 1'b0;
	reg         rst = 1'b1;
	reg         srst = 1'b0;
	reg         ext = 1'b1;
	reg         pm = 1'b0;
	reg         src = 1'b0;
	wire [15:0] bd;
	wire        dcs, rd_n, wr_n, t1, t234, err;
	wire [2:0]  p1, p234;
	wire [6:0]  hc, lc;
	wire [12:0] hl, ll;
	integer     miscompares = 0;
	integer     num_checks = 0;
	integer     n1 = 0;
	integer     n234 = 0;
	always #25 clk = ~clk;
	// ticks are unknown until the first reset edge
	always @(posedge clk)
	begin
		if (!rst)
		begin
			n1 <= n1 + t1;
			n234 <= n234 + t234;
		end
	end
	host_model host (.sys_clk(clk), .bus_data(bd), .data_command_select(dcs), .read_strobe_n(rd_n),
		.write_strobe_n(wr_n));
	pump_level_regs uut (.sys_clk(clk), .sys_rst(rst), .soft_reset(srst), .bus_data(bd),
		.data_command_select(dcs), .read_strobe_n(rd_n), .write_strobe_n(wr_n), .extended_cmd_enable(ext),
		.partial_mode(pm), .pump_source_clock(src), .pump1_partial_div(p1), .pump234_partial_div(p234),
		.common_high_code(hc), .common_low_code(lc), .common_high_level(hl), .common_low_level_mag(ll),
		.pump1_tick(t1), .pump234_tick(t234), .code_error(err));
	task chk(input [31:0] seen, input [31:0] exp);
	begin
		num_checks = num_checks + 1;
		if (seen !== exp)
		begin
			miscompares = miscompares + 1;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	end
	endtask
	task t_pump;
		integer c, a, b;
	begin
		for (c = 0; c < 7; c = c + 1)
		begin
			host.put(1'b0, 8'hc4);
			host.put(1'b1, {1'b0, c[2:0], 1'b0, c[2:0]});
			host.put(1'b1, 8'h55);
			chk({p1, p234}, {c[2:0], c[2:0]});
			a = n1;
			b = n234;
			pm = 1'b1;
			repeat (256)
			begin
				@(negedge clk) src = 1'b1;
				@(negedge clk) src = 1'b0;
			end
			repeat (4) @(negedge clk);
			pm = 1'b0;
			chk(n1 - a, 256 >> c);
			chk(n234 - b, 128 >> c);
		end
		$display("pump test done");
	end
	endtask
	task t_level;
	begin
		pm = 1'b1;
		host.put(1'b0, 8'hc5);
		host.put(1'b1, 8'hff);
		host.put(1'b1, 8'h64);
		host.put(1'b1, 8'h00);
		@(negedge clk);
		chk({hc, lc}, {7'h7f, 7'h64});
		chk({hl, ll}, {13'd5875, 13'd0});
		chk(err, 1'b0);
		pm = 1'b0;
		ext = 1'b0;
		host.put(1'b0, 8'hc5);
		ext = 1'b1;
		host.put(1'b1, 8'h10);
		chk({hc, lc}, {7'h7f, 7'h64});
		host.put(1'b0, 8'hc5);
		host.put(1'b1, 8'h05);
		host.put(1'b0, 8'hc4);
		host.put(1'b1, 8'h21);
		chk({hc, lc, p1, p234}, {7'h05, 7'h64, 3'h1, 3'h2});
		$display("level test done");
	end
	endtask
	task t_soft;
	begin
		srst = 1'b1;
		@(negedge clk);
		srst = 1'b0;
		@(negedge clk);
		chk({hc, lc, p1, p234}, {7'h31, 7'h3c, 3'h2, 3'h3});
		@(negedge clk);
		chk({hl, ll}, {13'd3925, 13'd1000});
		$display("soft reset test done");
	end
	endtask
	task close_out;
	begin
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask
	initial
	begin
		repeat (3) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		chk({hc, lc, p1, p234}, {7'h31, 7'h3c, 3'h2, 3'h3});
		t_pump;
		t_level;
		t_soft;
		close_out;
	end
endmodule // partial_pump_and_common_level_regs_tb
